//--- rtl/tcc_pkg.sv
// Constants for the timer 2 control and third compare/capture channel.
// Assumes an 8-bit special-function bus with byte addresses.
package tcc_pkg;

    // ------------------------------------------------------------------
    // Register addresses and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_COMPARE3_LOW   = 8'h00_C6;
    localparam logic [7:0] ADDR_COMPARE3_HIGH  = 8'h00_C7;
    localparam logic [7:0] ADDR_TIMER2_CONTROL = 8'h00_C8;
    localparam logic [7:0] RST_COMPARE3_LOW    = 8'h00_00;
    localparam logic [7:0] RST_COMPARE3_HIGH   = 8'h00_00;
    localparam logic [7:0] RST_TIMER2_CONTROL  = 8'h00_00;
    localparam logic [7:0] RDATA_UNMAPPED      = 8'h00_00;

    // ------------------------------------------------------------------
    // Field positions of the timer 2 control register
    // ------------------------------------------------------------------
    localparam int BIT_PRESCALE_SELECT = 7;
    localparam int BIT_IRQ3_EDGE       = 6;
    localparam int BIT_IRQ2_EDGE       = 5;
    localparam int BIT_RELOAD_HI       = 4;
    localparam int BIT_RELOAD_LO       = 3;
    localparam int BIT_COMPARE_STYLE   = 2;
    localparam int BIT_INPUT_MODE_HI   = 1;
    localparam int BIT_INPUT_MODE_LO   = 0;

    // ------------------------------------------------------------------
    // Timing: prescaler divisors in system clocks
    // ------------------------------------------------------------------
    localparam int          PRESCALE_DIV_SLOW = 24;
    localparam int          PRESCALE_DIV_FAST = 12;
    localparam logic [4:0]  PRESCALE_LAST_SLOW = 5'(PRESCALE_DIV_SLOW - 1);
    localparam logic [4:0]  PRESCALE_LAST_FAST = 5'(PRESCALE_DIV_FAST - 1);

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] CH_MODE_OFF        = 2'h0;
    localparam logic [1:0] CH_MODE_CAPT_EDGE  = 2'h1;
    localparam logic [1:0] CH_MODE_COMPARE    = 2'h2;
    localparam logic [1:0] CH_MODE_CAPT_WRITE = 2'h3;
    localparam logic [1:0] T2_IN_STOP         = 2'h0;
    localparam logic [1:0] T2_IN_TIMER        = 2'h1;
    localparam logic [1:0] T2_IN_COUNTER      = 2'h2;
    localparam logic [1:0] T2_IN_GATED        = 2'h3;

endpackage : tcc_pkg

//--- rtl/tcc_pin_sync.sv
// Pin synchroniser with agreement filter and edge detection.
// Assumes an asynchronous pin input and a single system clock.
`timescale 1ns/100ps
module tcc_pin_sync
(
    input  wire logic ref_clk,     // System clock
    input  wire logic sys_rst,     // Synchronous reset, active high
    input  wire logic pin_in,      // Asynchronous pin
    input  wire logic rise_sel,    // 1 selects rising, 0 falling edge
    output logic      level_q,     // Filtered pin level
    output logic      rise_q,      // One-cycle pulse on rising edge
    output logic      fall_q,      // One-cycle pulse on falling edge
    output logic      sel_edge_q   // One-cycle pulse on selected edge
);

    // ------------------------------------------------------------------
    // Three-stage synchroniser; level changes once stages 2 and 3 agree
    // ------------------------------------------------------------------
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_d;
    logic rise_d;
    logic fall_d;
    logic sel_edge_d;
    logic [2:0] fill_q;
    logic [2:0] fill_d;
    logic       armed;

    // Level is seeded from the settled pin after reset so an idle-high pin
    // gives no false edge; edges count only once the stages are filled
    always_comb
    begin
        armed      = fill_q[2];
        fill_d     = armed ? fill_q : fill_q + 3'h1;
        level_d    = !armed ? s3_q : ((s2_q == s3_q) ? s3_q : level_q);
        rise_d     = armed & level_d & ~level_q;
        fall_d     = armed & ~level_d & level_q;
        sel_edge_d = rise_sel ? rise_d : fall_d;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            s1_q       <= 1'b0;
            s2_q       <= 1'b0;
            s3_q       <= 1'b0;
            fill_q     <= 3'h0;
            level_q    <= 1'b0;
            rise_q     <= 1'b0;
            fall_q     <= 1'b0;
            sel_edge_q <= 1'b0;
        end
        else
        begin
            s1_q       <= pin_in;
            s2_q       <= s1_q;
            s3_q       <= s2_q;
            fill_q     <= fill_d;
            level_q    <= level_d;
            rise_q     <= rise_d;
            fall_q     <= fall_d;
            sel_edge_q <= sel_edge_d;
        end
    end

endmodule : tcc_pin_sync

//--- rtl/tcc_compare3.sv
// Timer 2 with its control register and the third compare/capture channel.
// Assumes an 8-bit special-function bus in the system clock domain and
// asynchronous external pins, which are synchronised here.
//
// Function
// (R1) Low byte of third compare/capture value at C6h, reset 00h.
// (R2) High byte at C7h, pairs with low byte into 16 bits, reset 00h.
// (R3) Channel captures timer 2 count or compares against it, per mode.
// (R4) Timer 2 control register at C8h, reset 00h, governs timer 2.
// (R5) Control bit 6 selects interrupt 3 edge: 0 falling, 1 rising.
// (R6) Control bit 5 selects interrupt 2 edge: 0 falling, 1 rising.
// (R7) Control bit 7 prescaler: 0 divides clock by 12, 1 by 24.
// (R8) Channel mode is two-bit field from mode-enable register bits 7:6.
// (R9) Compare style 0: match sets pin high until next timer 2 overflow.
// (R10) Compare style 1: match copies port latch to pin; overflow no change.
// (R11) Gated mode counts prescaled ticks only while gate pin allows.
`timescale 1ns/100ps
module tcc_compare3
(
    input  wire logic       ref_clk,              // System clock, 40 MHz
    input  wire logic       sys_rst,              // Synchronous reset, active high
    input  wire logic [7:0] sfr_addr,             // Register address
    input  wire logic       sfr_wr,               // Write strobe
    input  wire logic       sfr_rd,               // Read strobe
    input  wire logic [7:0] sfr_wdata,            // Write data
    output logic      [7:0] sfr_rdata,            // Read data, registered
    input  wire logic [1:0] compare_mode_enable,  // Mode field, bits 7:6 of mode register
    input  wire logic       compare_pin_in,       // Capture input pin
    input  wire logic       port_latch_bit,       // Pre-written port latch value
    input  wire logic       timer2_count_gate_pin,// Count / gate pin
    input  wire logic       external_irq_two,     // External interrupt 2 pin
    input  wire logic       external_irq_three,   // External interrupt 3 pin
    output logic            compare_pin,          // Compare output pin
    output logic            irq2_event,           // Pulse on selected interrupt 2 edge
    output logic            irq3_event,           // Pulse on selected interrupt 3 edge
    output logic     [15:0] timer2_count,         // Timer 2 count
    output logic            timer2_overflow       // Pulse when timer 2 wraps
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [7:0]  compare3_low_q;
    logic [7:0]  compare3_low_d;
    logic [7:0]  compare3_high_q;
    logic [7:0]  compare3_high_d;
    logic [7:0]  timer2_control_q;
    logic [7:0]  timer2_control_d;
    logic [7:0]  rdata_q;
    logic [7:0]  rdata_d;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [4:0]  presc_q;
    logic [4:0]  presc_d;
    logic        ovf_q;
    logic        ovf_d;
    logic        pin_q;
    logic        pin_d;
    logic        irq2_q;
    logic        irq3_q;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic gate_level;
    logic gate_fall;
    logic capt_edge;
    logic irq2_edge;
    logic irq3_edge;

    tcc_pin_sync u_gate
    (
        .ref_clk    (ref_clk),
        .sys_rst    (sys_rst),
        .pin_in     (timer2_count_gate_pin),
        .rise_sel   (1'b0),
        .level_q    (gate_level),
        .rise_q     (),
        .fall_q     (gate_fall),
        .sel_edge_q ()
    );

    // Capture pin edge follows the interrupt 3 edge selection
    tcc_pin_sync u_capt
    (
        .ref_clk    (ref_clk),
        .sys_rst    (sys_rst),
        .pin_in     (compare_pin_in),
        .rise_sel   (timer2_control_q[tcc_pkg::BIT_IRQ3_EDGE]),
        .level_q    (),
        .rise_q     (),
        .fall_q     (),
        .sel_edge_q (capt_edge)
    );

    tcc_pin_sync u_irq2
    (
        .ref_clk    (ref_clk),
        .sys_rst    (sys_rst),
        .pin_in     (external_irq_two),
        .rise_sel   (timer2_control_q[tcc_pkg::BIT_IRQ2_EDGE]), // R6
        .level_q    (),
        .rise_q     (),
        .fall_q     (),
        .sel_edge_q (irq2_edge)
    );

    tcc_pin_sync u_irq3
    (
        .ref_clk    (ref_clk),
        .sys_rst    (sys_rst),
        .pin_in     (external_irq_three),
        .rise_sel   (timer2_control_q[tcc_pkg::BIT_IRQ3_EDGE]), // R5
        .level_q    (),
        .rise_q     (),
        .fall_q     (),
        .sel_edge_q (irq3_edge)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    logic       wr_low;
    logic       wr_high;
    logic       wr_ctrl;
    logic       tick;
    logic       step;
    logic       capture;
    logic       match;
    logic [1:0] in_mode;
    logic [4:0] presc_last;

    always_comb
    begin
        wr_low     = sfr_wr && (sfr_addr == tcc_pkg::ADDR_COMPARE3_LOW);
        wr_high    = sfr_wr && (sfr_addr == tcc_pkg::ADDR_COMPARE3_HIGH);
        wr_ctrl    = sfr_wr && (sfr_addr == tcc_pkg::ADDR_TIMER2_CONTROL);
        in_mode    = {timer2_control_q[tcc_pkg::BIT_INPUT_MODE_HI],
                      timer2_control_q[tcc_pkg::BIT_INPUT_MODE_LO]};
        presc_last = timer2_control_q[tcc_pkg::BIT_PRESCALE_SELECT]
                   ? tcc_pkg::PRESCALE_LAST_SLOW
                   : tcc_pkg::PRESCALE_LAST_FAST; // R7

        // Prescaler runs whenever the timer input is a clocked mode
        presc_d = presc_q;
        tick    = 1'b0;
        if (in_mode == tcc_pkg::T2_IN_STOP || in_mode == tcc_pkg::T2_IN_COUNTER)
        begin
            presc_d = 5'h0_0;
        end
        else if (presc_q >= presc_last) // R7
        begin
            presc_d = 5'h0_0;
            tick    = 1'b1;
        end
        else
        begin
            presc_d = presc_q + 5'h0_1;
        end

        unique case (in_mode)
            tcc_pkg::T2_IN_STOP:    step = 1'b0;
            tcc_pkg::T2_IN_TIMER:   step = tick;
            tcc_pkg::T2_IN_COUNTER: step = gate_fall;
            tcc_pkg::T2_IN_GATED:   step = tick && gate_level; // R11
        endcase

        count_d = step ? count_q + 16'h0_001 : count_q;
        ovf_d   = step && (count_q == 16'hFFFF);

        // Channel mode decides capture or compare
        capture = ((compare_mode_enable == tcc_pkg::CH_MODE_CAPT_EDGE) && capt_edge)
               || ((compare_mode_enable == tcc_pkg::CH_MODE_CAPT_WRITE) && wr_low); // R3 R8
        match   = (compare_mode_enable == tcc_pkg::CH_MODE_COMPARE)
               && ({compare3_high_q, compare3_low_q} == count_q); // R3 R8

        // Capture wins over a software write in the same cycle
        compare3_low_d  = wr_low  ? sfr_wdata : compare3_low_q;   // R1
        compare3_high_d = wr_high ? sfr_wdata : compare3_high_q;  // R2
        if (capture)
        begin
            compare3_low_d  = count_q[7:0];   // R3
            compare3_high_d = count_q[15:8];  // R2
        end

        timer2_control_d = wr_ctrl ? sfr_wdata : timer2_control_q; // R4

        pin_d = pin_q;
        if (timer2_control_q[tcc_pkg::BIT_COMPARE_STYLE])
        begin
            if (match)
            begin
                pin_d = port_latch_bit; // R10
            end
        end
        else if (match)
        begin
            pin_d = 1'b1; // R9
        end
        else if (ovf_q)
        begin
            pin_d = 1'b0; // R9
        end

        rdata_d = rdata_q;
        if (sfr_rd)
        begin
            unique case (sfr_addr)
                tcc_pkg::ADDR_COMPARE3_LOW:   rdata_d = compare3_low_q;
                tcc_pkg::ADDR_COMPARE3_HIGH:  rdata_d = compare3_high_q;
                tcc_pkg::ADDR_TIMER2_CONTROL: rdata_d = timer2_control_q;
                default:                      rdata_d = tcc_pkg::RDATA_UNMAPPED;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            compare3_low_q   <= tcc_pkg::RST_COMPARE3_LOW;   // R1
            compare3_high_q  <= tcc_pkg::RST_COMPARE3_HIGH;  // R2
            timer2_control_q <= tcc_pkg::RST_TIMER2_CONTROL; // R4
            rdata_q          <= 8'h00_00;
            count_q          <= 16'h0_000;
            presc_q          <= 5'h0_0;
            ovf_q            <= 1'b0;
            pin_q            <= 1'b0;
            irq2_q           <= 1'b0;
            irq3_q           <= 1'b0;
        end
        else
        begin
            compare3_low_q   <= compare3_low_d;
            compare3_high_q  <= compare3_high_d;
            timer2_control_q <= timer2_control_d;
            rdata_q          <= rdata_d;
            count_q          <= count_d;
            presc_q          <= presc_d;
            ovf_q            <= ovf_d;
            pin_q            <= pin_d;
            irq2_q           <= irq2_edge; // R6
            irq3_q           <= irq3_edge; // R5
        end
    end

    assign sfr_rdata       = rdata_q;
    assign compare_pin     = pin_q;
    assign irq2_event      = irq2_q;
    assign irq3_event      = irq3_q;
    assign timer2_count    = count_q;
    assign timer2_overflow = ovf_q;

endmodule : tcc_compare3

//--- testbench/tcc_compare3_assertions.sv
// Checker for tcc_compare3, watching its ports only.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module tcc_compare3_assertions
(
    input wire logic        ref_clk,               // Clock
    input wire logic        sys_rst,               // Reset
    input wire logic [7:0]  sfr_addr,              // Address
    input wire logic        sfr_wr,                // Write
    input wire logic        sfr_rd,                // Read
    input wire logic [7:0]  sfr_wdata,             // Write data
    input wire logic [7:0]  sfr_rdata,             // Read data
    input wire logic [1:0]  compare_mode_enable,   // Mode
    input wire logic        compare_pin_in,        // Capture pin
    input wire logic        port_latch_bit,        // Latch
    input wire logic        timer2_count_gate_pin, // Gate
    input wire logic        external_irq_two,      // Irq 2 pin
    input wire logic        external_irq_three,    // Irq 3 pin
    input wire logic        compare_pin,           // Compare out
    input wire logic        irq2_event,            // Irq 2 event
    input wire logic        irq3_event,            // Irq 3 event
    input wire logic [15:0] timer2_count,          // Count
    input wire logic        timer2_overflow        // Overflow
);
    // ------------------------------------------------------------------
    // Shadow of control, compare value and count steps
    // ------------------------------------------------------------------
    logic [7:0]  ctl_q;
    logic [15:0] cmp_q;
    logic [15:0] cnt_q;
    logic [1:0]  ok_q;
    logic [4:0]  gap_q;
    logic        seen_q;
    logic        wr_ctl;
    logic        is_cmp;
    logic        step;
    logic        hit;

    assign wr_ctl = sfr_wr && sfr_addr == 8'hC8;
    assign is_cmp = compare_mode_enable == tcc_pkg::CH_MODE_COMPARE;
    assign step   = timer2_count != cnt_q;
    assign hit    = is_cmp && (&ok_q) && timer2_count == cmp_q;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            ctl_q  <= 8'h00;
            ok_q   <= 2'h0;
            cnt_q  <= 16'h0000;
            gap_q  <= 5'h00;
            seen_q <= 1'b0;
        end
        else
        begin
            if (wr_ctl)
                ctl_q <= sfr_wdata;
            if (!is_cmp)
                ok_q <= 2'h0;
            else if (sfr_wr && sfr_addr[7:1] == 7'h63)
                ok_q[sfr_addr[0]] <= 1'b1;
            if (sfr_wr && sfr_addr[7:1] == 7'h63)
                cmp_q[{sfr_addr[0], 3'h0} +: 8] <= sfr_wdata;
            cnt_q  <= timer2_count;
            gap_q  <= step ? 5'h00 : gap_q + {4'h0, gap_q != 5'h1F};
            seen_q <= !wr_ctl && (seen_q || step);
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    unmapped_read_a: assert property (sfr_rd && (sfr_addr < 8'hC6 || sfr_addr > 8'hC8)
        |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
    ctl_readback_a: assert property (sfr_rd && !sfr_wr && sfr_addr == 8'hC8
        |=> sfr_rdata == ctl_q) else $error("control readback wrong");
    irq2_edge_a: assert property (irq2_event
        |-> external_irq_two == ctl_q[5] ##1 !irq2_event) else $error("irq2 event wrong");
    irq3_edge_a: assert property (irq3_event
        |-> external_irq_three == ctl_q[6] ##1 !irq3_event) else $error("irq3 event wrong");
    count_step_a: assert property (step
        |-> timer2_count == cnt_q + 16'h0001) else $error("count step not one");
    prescale_gap_a: assert property (step && seen_q && ctl_q[1:0] == 2'h1
        |-> gap_q == (ctl_q[7] ? 5'd23 : 5'd11)) else $error("prescale period wrong");
    stop_hold_a: assert property ((ctl_q[1:0] == 2'h0) [*2] |=> !step)
        else $error("stopped timer moved");
    gate_hold_a: assert property ((ctl_q[1:0] == 2'h3 && !timer2_count_gate_pin) [*8]
        |=> !step) else $error("gated timer moved");
    match_set_a: assert property (hit && !ctl_q[2] |=> compare_pin)
        else $error("match did not set pin");
    match_latch_a: assert property (hit && ctl_q[2]
        |=> compare_pin == $past(port_latch_bit)) else $error("match did not copy latch");
    ovf_pulse_a: assert property (timer2_overflow
        |-> timer2_count == 16'h0000 ##1 !timer2_overflow) else $error("overflow pulse wrong");
    ovf_clear_a: assert property (timer2_overflow && !ctl_q[2] && !hit
        && (&ok_q || !is_cmp) |=> !compare_pin) else $error("overflow did not clear pin");
    ovf_keep_a: assert property (timer2_overflow && ctl_q[2] && !hit
        && (&ok_q || !is_cmp) |=> $stable(compare_pin)) else $error("overflow moved pin");

    cover property ($rose(compare_pin));
    cover property (irq3_event && ctl_q[6]);
    cover property (step && seen_q && ctl_q[7]);
endmodule : tcc_compare3_assertions

//--- testbench/tcc_pin_model.sv
// Pin model: interrupt, gate, capture and port latch lines.
// Assumes the bench calls drive_pin just after a falling clock edge.
`timescale 1ns/100ps
module tcc_pin_model
(
    output logic irq_two,   // Interrupt 2 pin, idles high
    output logic irq_three, // Interrupt 3 pin, idles high
    output logic gate,      // Count gate pin
    output logic capture,   // Capture pin
    output logic latch      // Port latch bit
);
    initial
    begin
        irq_two   = 1'b1;
        irq_three = 1'b1;
        gate      = 1'b0;
        capture   = 1'b0;
        latch     = 1'b0;
    end

    task automatic drive_pin(input int idx, input logic v);
        case (idx)
            0: irq_two = v;
            1: irq_three = v;
            2: gate = v;
            3: capture = v;
            default: latch = v;
        endcase
    endtask : drive_pin
endmodule : tcc_pin_model

//--- testbench/tcc_compare3_tb.sv
// Self-checking bench for tcc_compare3 with a pin model on its far side.
// Assumes the package, design, checker and pin model are compiled first.
`timescale 1ns/100ps
module tcc_compare3_tb;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  sfr_addr = 8'h00;
    logic        sfr_wr = 1'b0;
    logic        sfr_rd = 1'b0;
    logic [7:0]  sfr_wdata = 8'h00;
    logic [1:0]  mode = 2'h0;
    logic [7:0]  sfr_rdata;
    logic        irq2_pin, irq3_pin, gate_pin, cap_pin, latch_bit;
    logic        compare_pin, irq2_event, irq3_event, timer2_overflow;
    logic [15:0] timer2_count;
    int          failures = 0;
    int          n_tests = 0;
    int          ev2 = 0;
    int          ev3 = 0;
    int          ovf = 0;

    always #12.5 ref_clk = ~ref_clk;
    always @(negedge ref_clk)
    begin
        ev2 = ev2 + int'(irq2_event === 1'b1);
        ev3 = ev3 + int'(irq3_event === 1'b1);
        ovf = ovf + int'(timer2_overflow !== 1'b0);
    end

    tcc_pin_model u_tcc_pin_model (.irq_two(irq2_pin), .irq_three(irq3_pin), .gate(gate_pin),
        .capture(cap_pin), .latch(latch_bit));
    tcc_compare3 u_tcc_compare3 (.ref_clk(ref_clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .compare_mode_enable(mode), .compare_pin_in(cap_pin), .port_latch_bit(latch_bit),
        .timer2_count_gate_pin(gate_pin), .external_irq_two(irq2_pin),
        .external_irq_three(irq3_pin), .compare_pin(compare_pin), .irq2_event(irq2_event),
        .irq3_event(irq3_event), .timer2_count(timer2_count), .timer2_overflow(timer2_overflow));

    // ------------------------------------------------------------------
    // Bus, compare and wait tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %0t %s: got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr    = 1'b1;
        @(negedge ref_clk);
        sfr_wr    = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_rd   = 1'b1;
        @(negedge ref_clk);
        sfr_rd   = 1'b0;
        d        = sfr_rdata;
    endtask : rd

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(16'(d), 16'(exp), "register read");
    endtask : rchk

    task automatic wait_on(input logic want_pin, input logic v, output int n);
        logic [15:0] c;
        c = timer2_count;
        for (n = 0; n < 600 && (want_pin ? compare_pin !== v : timer2_count === c); n++)
            @(negedge ref_clk);
        if (n == 600)
        begin
            failures++;
            end_of_test();
        end
    endtask : wait_on

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs();
        rchk(8'hC6, 8'h00);
        rchk(8'hC7, 8'h00);
        rchk(8'hC8, 8'h00);
        rchk(8'hC9, 8'h00);
        wr(8'hC6, 8'hA5);
        wr(8'hC7, 8'h5A);
        wr(8'hC8, 8'hE4);
        rchk(8'hC6, 8'hA5);
        rchk(8'hC7, 8'h5A);
        rchk(8'hC8, 8'hE4);
    endtask : t_regs

    task automatic t_edges();
        int b2, b3;
        for (int s = 0; s < 4; s++)
        begin
            wr(8'hC8, {1'b0, s[1], s[0], 5'h00});
            for (int lv = 0; lv < 2; lv++)
            begin
                b2 = ev2;
                b3 = ev3;
                u_tcc_pin_model.drive_pin(0, lv[0]);
                u_tcc_pin_model.drive_pin(1, lv[0]);
                repeat (12) @(negedge ref_clk);
                chk(16'(ev2 - b2), 16'(lv == s[0]), "irq2 events");
                chk(16'(ev3 - b3), 16'(lv == s[1]), "irq3 events");
            end
        end
    endtask : t_edges

    task automatic t_timer();
        int n;
        logic [15:0] b;
        for (int p = 0; p < 2; p++)
        begin
            wr(8'hC8, p ? 8'h81 : 8'h01);
            wait_on(1'b0, 1'b0, n);
            wait_on(1'b0, 1'b0, n);
            chk(16'(n), p ? 16'h0018 : 16'h000C, "prescale period");
        end
        wr(8'hC8, 8'h03);
        u_tcc_pin_model.drive_pin(2, 1'b0);
        repeat (8) @(negedge ref_clk);
        b = timer2_count;
        repeat (40) @(negedge ref_clk);
        chk(timer2_count, b, "gate low holds");
        u_tcc_pin_model.drive_pin(2, 1'b1);
        repeat (40) @(negedge ref_clk);
        chk(16'(timer2_count !== b), 16'h0001, "gate high counts");
        wr(8'hC8, 8'h02);
        b = timer2_count;
        u_tcc_pin_model.drive_pin(2, 1'b0);
        repeat (8) @(negedge ref_clk);
        chk(timer2_count, b + 16'h0001, "gate fall counts");
        u_tcc_pin_model.drive_pin(2, 1'b1);
        repeat (8) @(negedge ref_clk);
        chk(timer2_count, b + 16'h0001, "gate rise ignored");
        wr(8'hC8, 8'h00);
        repeat (2) @(negedge ref_clk);
        b = timer2_count;
        repeat (30) @(negedge ref_clk);
        chk(timer2_count, b, "stopped timer holds");
        chk(16'(ovf), 16'h0000, "timer wrapped early");
    endtask : t_timer

    task automatic t_capture();
        logic [7:0]  lo, hi;
        logic [15:0] b;
        wr(8'hC8, 8'h41);
        for (int m = 1; m < 4; m += 2)
        begin
            mode = 2'(m);
            b = timer2_count;
            if (m == 1)
                u_tcc_pin_model.drive_pin(3, 1'b1);
            else
                wr(8'hC6, 8'hFF);
            repeat (10) @(negedge ref_clk);
            rd(8'hC6, lo);
            rd(8'hC7, hi);
            chk(16'({hi, lo} >= b && {hi, lo} <= timer2_count), 16'h0001, "capture");
        end
    endtask : t_capture

    task automatic t_compare();
        int          n;
        logic [15:0] t;
        mode = 2'h2;
        for (int k = 0; k < 3; k++)
        begin
            u_tcc_pin_model.drive_pin(4, k[1]);
            wr(8'hC8, k > 0 ? 8'h05 : 8'h01);
            t = timer2_count + 16'h0004;
            wr(8'hC7, t[15:8]);
            wr(8'hC6, t[7:0]);
            wait_on(1'b1, k != 1, n);
            chk(timer2_count, t, "match moment");
            repeat (13) @(negedge ref_clk);
        end
    endtask : t_compare

    initial
    begin
        repeat (2) @(negedge ref_clk);
        sys_rst = 1'b0;
        repeat (10) @(negedge ref_clk);
        t_regs();
        t_edges();
        t_timer();
        t_capture();
        t_compare();
        end_of_test();
    end
endmodule : tcc_compare3_tb

bind tcc_compare3 tcc_compare3_assertions u_tcc_compare3_assertions (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .compare_mode_enable(compare_mode_enable),
    .compare_pin_in(compare_pin_in), .port_latch_bit(port_latch_bit),
    .timer2_count_gate_pin(timer2_count_gate_pin), .external_irq_two(external_irq_two),
    .external_irq_three(external_irq_three), .compare_pin(compare_pin),
    .irq2_event(irq2_event), .irq3_event(irq3_event), .timer2_count(timer2_count),
    .timer2_overflow(timer2_overflow));
